// >>> hdl/mic_pkg.sv
// Constants, register map and field layout of the interrupt controller
// Behaviour
// - Up to fourteen sources, each with its own request flag bit.
// - Flags set on their event whatever the source or global enables say.
// - Global enable at control bit 7 passes unmasked requests, blocks all when zero.
// - Global enable plus any core flag-and-enable pair, or a peripheral pair with the group enable, sends the core to the vector.
// - Reset clears the global enable.
// - Acceptance clears global enable, pushes return address, loads PC with 0004h.
// - Return-from-interrupt operation sets the global enable again.
// - Edge-pin and port-change events reach the vector in three or four cycles.
// - Peripheral flags and enables sit in two register pairs; group enable in control.
// - External pin edge-triggered; edge select one means rising, zero falling.
// - Valid pin edge sets control bit 1; enable at control bit 4.
// - Pin request wakes from sleep only with its enable set; global picks branching.
// - Timer rollover FFh to 00h sets control bit 2, enabled by control bit 5.
// - Change on upper four port pins sets control bit 0.
// - Entry saves only the return PC; nothing else is saved by hardware.
// - Wake with global enable set loads the vector; flags show the waking event.
// - Enabled request wakes regardless of global enable; clear means continue after sleep.
// - Pending enabled request before sleep makes the sleep a no-operation.
package mic_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_OPTION       = 8'h01;
	localparam logic [7:0] OFS_PERIPH_FLG_A = 8'h02;
	localparam logic [7:0] OFS_PERIPH_FLG_B = 8'h03;
	localparam logic [7:0] OFS_PERIPH_ENA_A = 8'h04;
	localparam logic [7:0] OFS_PERIPH_ENA_B = 8'h05;

	// ----------------------------------------------------------------
	// Control register field positions, and the option register edge select bit
	// ----------------------------------------------------------------
	localparam int BIT_GLOBAL_EN   = 7;
	localparam int BIT_PERIPH_EN   = 6;
	localparam int BIT_TIMER_EN    = 5;
	localparam int BIT_EXT_EN      = 4;
	localparam int BIT_PORT_EN     = 3;
	localparam int BIT_TIMER_FLAG  = 2;
	localparam int BIT_EXT_FLAG    = 1;
	localparam int BIT_PORT_FLAG   = 0;
	localparam int BIT_EDGE_SELECT = 6;

	// ----------------------------------------------------------------
	// Reset values, vector address, timing and source counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_IRQ_CONTROL = 8'h00;
	localparam logic        RST_EDGE_SELECT = 1'b1;
	localparam logic [15:0] RST_PERIPH      = 16'h0000;
	localparam logic [12:0] IRQ_VECTOR_ADDR = 13'h0004;
	localparam int          CLKS_PER_INSTR  = 4;
	localparam int          ACCEPT_STAGES   = 2;
	localparam int          CORE_SOURCES    = 3;
	localparam int          MAX_SOURCES     = 14;

endpackage : mic_pkg

// >>> hdl/mic_event_detect.sv
// Edge detection for the external pin and change detection on the upper port pins
`timescale 1ns/100ps
module mic_event_detect (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Pins and edge choice
	input  wire logic       ext_irq_pin,
	input  wire logic [3:0] port_b_pins,
	input  wire logic       ext_edge_select,
	// Event pulses
	output logic            ext_edge_evt,
	output logic            port_change_evt
);
	import mic_pkg::*;

	logic       ext_last;
	logic [3:0] port_last;
	logic       primed;

	// Previous pin levels, primed after first sample so reset gives no false event
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_last  <= 1'b0;
			port_last <= 4'h0;
			primed    <= 1'b0;
		end else begin
			ext_last  <= ext_irq_pin;
			port_last <= port_b_pins;
			primed    <= 1'b1;
		end
	end

	// Pin edge and port change pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_edge_evt    <= 1'b0;
			port_change_evt <= 1'b0;
		end else begin
			ext_edge_evt    <= primed && (ext_edge_select ? (ext_irq_pin && !ext_last)
			                                              : (!ext_irq_pin && ext_last));
			port_change_evt <= primed && (port_b_pins != port_last);
		end
	end

endmodule : mic_event_detect

// >>> hdl/mcu_interrupt_control.sv
// Interrupt controller: flags, masks, vectoring and sleep wake-up
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
module mcu_interrupt_control #(
	parameter int NUM_PERIPH = 11
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// Event sources
	input  wire logic        ext_irq_pin,
	input  wire logic [3:0]  port_b_pins,
	input  wire logic        timer_rollover,
	input  wire logic [15:0] periph_events,
	// Core handshake
	input  wire logic        sleep_exec,
	input  wire logic        return_from_irq_op,
	output logic             irq_vector_req,
	output logic             push_return,
	output logic [12:0]      vector_addr,
	output logic             core_asleep,
	output logic             wake_req,
	output logic             sleep_as_nop,
	output logic             instr_en
);
	import mic_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (NUM_PERIPH < 1 || NUM_PERIPH + CORE_SOURCES > MAX_SOURCES) begin : g_bad_param
			$error("NUM_PERIPH out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  irq_control_reg;
	logic        ext_edge_select;
	logic [15:0] periph_flags;
	logic [15:0] periph_enables;
	logic [15:0] impl_mask;
	logic        ext_edge_evt;
	logic        port_change_evt;
	logic [1:0]  div_cnt;
	logic [1:0]  accept_cnt;
	logic        accepting;
	logic        accept_now;
	logic        core_pending;
	logic        periph_pending;
	logic        any_pending;
	logic        wr_ctrl;
	logic        wr_flg_a;
	logic        wr_flg_b;
	logic        wr_ena_a;
	logic        wr_ena_b;
	logic [7:0]  next_ctrl;
	logic [15:0] next_pflags;
	logic [7:0]  next_rdata;

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	mic_event_detect u_detect (
		.ref_clk         (ref_clk),
		.rst_n           (rst_n),
		.ext_irq_pin     (ext_irq_pin),
		.port_b_pins     (port_b_pins),
		.ext_edge_select (ext_edge_select),
		.ext_edge_evt    (ext_edge_evt),
		.port_change_evt (port_change_evt)
	);

	// ----------------------------------------------------------------
	// Instruction cycle divider
	// ----------------------------------------------------------------
	// One enable pulse every CLKS_PER_INSTR clocks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt  <= 2'h0;
			instr_en <= 1'b0;
		end else begin
			div_cnt  <= (div_cnt == 2'(CLKS_PER_INSTR - 1)) ? 2'h0 : div_cnt + 2'h1;
			instr_en <= (div_cnt == 2'(CLKS_PER_INSTR - 1));
		end
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_ctrl  = reg_wr && (reg_addr == OFS_IRQ_CONTROL);
	assign wr_flg_a = reg_wr && (reg_addr == OFS_PERIPH_FLG_A);
	assign wr_flg_b = reg_wr && (reg_addr == OFS_PERIPH_FLG_B);
	assign wr_ena_a = reg_wr && (reg_addr == OFS_PERIPH_ENA_A);
	assign wr_ena_b = reg_wr && (reg_addr == OFS_PERIPH_ENA_B);

	// ----------------------------------------------------------------
	// Implemented peripheral positions
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < 16; i++) begin : g_impl
			assign impl_mask[i] = (i < NUM_PERIPH);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Request evaluation
	// ----------------------------------------------------------------
	// Gated core sources and peripheral group, before the global gate
	always_comb begin
		core_pending = (irq_control_reg[BIT_EXT_FLAG]   && irq_control_reg[BIT_EXT_EN])
		            || (irq_control_reg[BIT_TIMER_FLAG] && irq_control_reg[BIT_TIMER_EN])
		            || (irq_control_reg[BIT_PORT_FLAG]  && irq_control_reg[BIT_PORT_EN]);
		periph_pending = irq_control_reg[BIT_PERIPH_EN]
		              && |(periph_flags & periph_enables & impl_mask);
		any_pending = core_pending || periph_pending;
	end

	// Acceptance fires on an instruction boundary once the pipeline has run
	assign accept_now = instr_en && accepting && (accept_cnt == 2'(ACCEPT_STAGES - 1))
	                 && irq_control_reg[BIT_GLOBAL_EN] && any_pending && !core_asleep;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Hardware sets win over a software clear in the same cycle
	always_comb begin
		next_ctrl = irq_control_reg;
		if (wr_ctrl) begin
			next_ctrl = reg_wdata;
		end
		if (ext_edge_evt) begin
			next_ctrl[BIT_EXT_FLAG] = 1'b1;
		end
		if (timer_rollover) begin
			next_ctrl[BIT_TIMER_FLAG] = 1'b1;
		end
		if (port_change_evt) begin
			next_ctrl[BIT_PORT_FLAG] = 1'b1;
		end
		if (return_from_irq_op) begin
			next_ctrl[BIT_GLOBAL_EN] = 1'b1;
		end
		if (accept_now) begin
			next_ctrl[BIT_GLOBAL_EN] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_control_reg <= RST_IRQ_CONTROL;
		end else begin
			irq_control_reg <= next_ctrl;
		end
	end

	// ----------------------------------------------------------------
	// Option and peripheral registers
	// ----------------------------------------------------------------
	// Edge select
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_edge_select <= RST_EDGE_SELECT;
		end else if (reg_wr && reg_addr == OFS_OPTION) begin
			ext_edge_select <= reg_wdata[BIT_EDGE_SELECT];
		end
	end

	// Peripheral flags, event set beats software clear
	always_comb begin
		next_pflags = periph_flags;
		if (wr_flg_a) begin
			next_pflags[7:0] = reg_wdata;
		end
		if (wr_flg_b) begin
			next_pflags[15:8] = reg_wdata;
		end
		next_pflags = (next_pflags | periph_events) & impl_mask;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_flags <= RST_PERIPH;
		end else begin
			periph_flags <= next_pflags;
		end
	end

	// Peripheral enables
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_enables <= RST_PERIPH;
		end else begin
			if (wr_ena_a) begin
				periph_enables[7:0] <= reg_wdata & impl_mask[7:0];
			end
			if (wr_ena_b) begin
				periph_enables[15:8] <= reg_wdata & impl_mask[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			OFS_IRQ_CONTROL:  next_rdata = irq_control_reg;
			OFS_OPTION:       next_rdata = {1'b0, ext_edge_select, 6'h00};
			OFS_PERIPH_FLG_A: next_rdata = periph_flags[7:0];
			OFS_PERIPH_FLG_B: next_rdata = periph_flags[15:8];
			OFS_PERIPH_ENA_A: next_rdata = periph_enables[7:0];
			OFS_PERIPH_ENA_B: next_rdata = periph_enables[15:8];
			default:          next_rdata = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Acceptance pipeline
	// ----------------------------------------------------------------
	// Counts instruction boundaries while a gated request stands
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			accepting  <= 1'b0;
			accept_cnt <= 2'h0;
		end else if (!(irq_control_reg[BIT_GLOBAL_EN] && any_pending) || core_asleep
		             || accept_now) begin
			accepting  <= 1'b0;
			accept_cnt <= 2'h0;
		end else if (instr_en) begin
			if (!accepting) begin
				accepting <= 1'b1;
			end else begin
				accept_cnt <= accept_cnt + 2'h1;
			end
		end
	end

	// Vector request and return push, one clock each; only the PC is saved
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_vector_req <= 1'b0;
			push_return    <= 1'b0;
			vector_addr    <= 13'h0000;
		end else begin
			irq_vector_req <= accept_now;
			push_return    <= accept_now;
			vector_addr    <= IRQ_VECTOR_ADDR;
		end
	end

	// ----------------------------------------------------------------
	// Sleep control
	// ----------------------------------------------------------------
	// Enabled request ends sleep whatever the global enable holds
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_asleep  <= 1'b0;
			wake_req     <= 1'b0;
			sleep_as_nop <= 1'b0;
		end else begin
			wake_req     <= 1'b0;
			sleep_as_nop <= 1'b0;
			if (sleep_exec && !core_asleep) begin
				if (any_pending) begin
					sleep_as_nop <= 1'b1;
				end else begin
					core_asleep <= 1'b1;
				end
			end else if (core_asleep && any_pending) begin
				core_asleep <= 1'b0;
				wake_req    <= 1'b1;
			end
		end
	end

endmodule : mcu_interrupt_control

// >>> verif/mic_assertions.sv
// Port-level checks of the interrupt controller
`timescale 1ns/100ps
module mic_checker
	import mic_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Observed ports
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        sleep_exec,
	input wire logic        irq_vector_req,
	input wire logic        push_return,
	input wire logic [12:0] vector_addr,
	input wire logic        core_asleep,
	input wire logic        wake_req,
	input wire logic        sleep_as_nop,
	input wire logic        instr_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Vectoring, instruction timing and read data
	// ------------------------------------------------------------
	a_vector_fixed: assert property ($past(rst_n) |-> vector_addr == IRQ_VECTOR_ADDR)
		else $error("vector address wrong");
	a_push_paired: assert property (irq_vector_req |-> push_return
		##1 !irq_vector_req && !push_return)
		else $error("push not paired with vector");
	a_accept_boundary: assert property (irq_vector_req |-> $past(instr_en))
		else $error("vector off instruction boundary");
	a_instr_period: assert property (instr_en |=> !instr_en [*3] ##1 instr_en)
		else $error("instruction cycle not four clocks");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	// ------------------------------------------------------------
	// Sleep and wake
	// ------------------------------------------------------------
	a_nop_cause: assert property (sleep_as_nop |-> $past(sleep_exec) && !core_asleep)
		else $error("no-op without sleep request");
	a_sleep_result: assert property (sleep_exec && !core_asleep
		|=> core_asleep != sleep_as_nop)
		else $error("sleep neither entered nor skipped");
	a_wake_exit: assert property (wake_req |-> $past(core_asleep) && !core_asleep)
		else $error("wake without sleep");
	a_asleep_quiet: assert property (core_asleep |-> !irq_vector_req)
		else $error("vector while asleep");
	// Main scenarios reached
	c_vector: cover property (irq_vector_req);
	c_wake: cover property (wake_req);
	c_nop: cover property (sleep_as_nop);
endmodule : mic_checker

// >>> verif/mic_core_model.sv
// Processor core model issuing sleep and return operations
`timescale 1ns/100ps
module mic_core_model (
	// Clock
	input wire logic ref_clk,
	// Core operations
	output logic     sleep_exec,
	output logic     return_from_irq_op
);
	initial begin
		sleep_exec = 1'b0;
		return_from_irq_op = 1'b0;
	end
	// One-cycle operation pulse, return when ret is set
	task automatic pulse(input bit ret);
		@(posedge ref_clk);
		return_from_irq_op <= ret;
		sleep_exec <= !ret;
		@(posedge ref_clk);
		return_from_irq_op <= 1'b0;
		sleep_exec <= 1'b0;
	endtask : pulse
endmodule : mic_core_model

// >>> verif/test_mcu_interrupt_control.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
module test_mcu_interrupt_control;
	import mic_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ext_irq_pin = 1'b0;
	logic [3:0]  port_b_pins = 4'h0;
	logic        timer_rollover = 1'b0;
	logic [15:0] periph_events = 16'h0000;
	logic [7:0]  reg_rdata;
	logic [12:0] vector_addr;
	logic        sleep_exec, return_from_irq_op, irq_vector_req, push_return;
	logic        core_asleep, wake_req, sleep_as_nop, instr_en;
	logic [7:0]  m [0:5] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk [0:5] = '{8'hff, 8'h40, 8'hff, 8'h07, 8'hff, 8'h07};
	logic [31:0] xs = 32'hdcccb790;
	logic [31:0] r;
	int          err_count = 0;
	int          compares = 0;
	int          n;

	always #12.5 ref_clk = ~ref_clk;
	mcu_interrupt_control #(.NUM_PERIPH(11)) u_dut (
		.ref_clk            (ref_clk),
		.rst_n              (rst_n),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.ext_irq_pin        (ext_irq_pin),
		.port_b_pins        (port_b_pins),
		.timer_rollover     (timer_rollover),
		.periph_events      (periph_events),
		.sleep_exec         (sleep_exec),
		.return_from_irq_op (return_from_irq_op),
		.irq_vector_req     (irq_vector_req),
		.push_return        (push_return),
		.vector_addr        (vector_addr),
		.core_asleep        (core_asleep),
		.wake_req           (wake_req),
		.sleep_as_nop       (sleep_as_nop),
		.instr_en           (instr_en)
	);
	mic_core_model u_core (
		.ref_clk            (ref_clk),
		.sleep_exec         (sleep_exec),
		.return_from_irq_op (return_from_irq_op)
	);

	function automatic logic [31:0] nxt();
		xs ^= xs << 13;
		xs ^= xs >> 17;
		xs ^= xs << 5;
		return xs;
	endfunction : nxt
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// Register bus cycles, model follows writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (a < 8'h06) m[a] = d & msk[a];
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	// Source events with flag model
	task automatic ev(input logic t, input logic [15:0] pe, input logic pin, input logic [3:0] pb);
		@(posedge ref_clk);
		if (pin !== ext_irq_pin && pin === m[1][6]) m[0][1] = 1'b1;
		if (pb !== port_b_pins) m[0][0] = 1'b1;
		m[0][2] = m[0][2] | t;
		m[2] = m[2] | pe[7:0];
		m[3] = m[3] | (pe[15:8] & 8'h07);
		timer_rollover <= t;
		periph_events <= pe;
		ext_irq_pin <= pin;
		port_b_pins <= pb;
		@(posedge ref_clk);
		timer_rollover <= 1'b0;
		periph_events <= 16'h0000;
		repeat (2) @(posedge ref_clk);
	endtask : ev
	// Bounded wait for a vector or a wake pulse
	task automatic wt(input bit w, input bit must, input int lim);
		n = 0;
		while ((w ? wake_req : irq_vector_req) !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		// Vector seen: global enable dropped, return pushed, fixed address shown
		if (!w && n < lim) begin
			m[0][7] = 1'b0;
			chk({7'h00, push_return}, 8'h01);
			chk(vector_addr[7:0], IRQ_VECTOR_ADDR[7:0]);
			chk({3'h0, vector_addr[12:8]}, {3'h0, IRQ_VECTOR_ADDR[12:8]});
		end
		if (must && n >= lim) begin
			err_count++;
			end_of_test();
		end
	endtask : wt

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 7; a++) rd(a[7:0], a < 6 ? m[a] : 8'h00);
		$display("reset values done");
		for (int i = 0; i < 6; i++) begin
			r = nxt();
			wr(OFS_OPTION, {1'b0, r[0], 6'h00});
			ev(r[1], r[31:16], r[2], r[7:4]);
			for (int a = 0; a < 6; a++) rd(a[7:0], m[a]);
		end
		wr(OFS_IRQ_CONTROL, 8'h00);
		wr(OFS_PERIPH_FLG_A, 8'h00);
		wr(OFS_PERIPH_FLG_B, 8'h00);
		$display("flag events done");
		wr(OFS_PERIPH_ENA_A, 8'h01);
		wr(OFS_PERIPH_FLG_A, 8'h01);
		wr(OFS_IRQ_CONTROL, 8'h80);
		wt(1'b0, 1'b0, 40);
		chk({7'h00, n >= 40}, 8'h01);
		wr(OFS_IRQ_CONTROL, 8'hc0);
		wt(1'b0, 1'b1, 40);
		rd(OFS_IRQ_CONTROL, m[0]);
		u_core.pulse(1'b1);
		m[0][7] = 1'b1;
		wt(1'b0, 1'b1, 40);
		wr(OFS_PERIPH_FLG_A, 8'h00);
		u_core.pulse(1'b1);
		m[0][7] = 1'b1;
		wt(1'b0, 1'b0, 40);
		rd(OFS_IRQ_CONTROL, m[0]);
		wr(OFS_IRQ_CONTROL, 8'h40);
		wr(OFS_PERIPH_FLG_A, 8'h01);
		wt(1'b0, 1'b0, 40);
		chk({7'h00, n >= 40}, 8'h01);
		wr(OFS_PERIPH_FLG_A, 8'h00);
		$display("vectoring done");
		for (int k = 0; k < 3; k++) begin
			ev(1'b0, 16'h0000, k != 0, port_b_pins);
			wr(OFS_OPTION, k == 0 ? 8'h40 : 8'h00);
			wr(OFS_IRQ_CONTROL, k == 2 ? 8'h88 : 8'h90);
			r = nxt();
			repeat (r[1:0]) @(posedge ref_clk);
			@(posedge ref_clk);
			if (k == 2) port_b_pins <= ~port_b_pins;
			else ext_irq_pin <= ~ext_irq_pin;
			wt(1'b0, 1'b1, 30);
			// Core takes the vector at the edge after the pulse
			n++;
			chk({7'h00, n >= 3 * CLKS_PER_INSTR && n <= 4 * CLKS_PER_INSTR}, 8'h01);
			wr(OFS_IRQ_CONTROL, 8'h00);
		end
		$display("latency done");
		wr(OFS_OPTION, 8'h40);
		ev(1'b0, 16'h0000, 1'b0, port_b_pins);
		wr(OFS_IRQ_CONTROL, 8'h10);
		u_core.pulse(1'b0);
		#1 chk({7'h00, core_asleep}, 8'h01);
		@(posedge ref_clk);
		ext_irq_pin <= 1'b1;
		m[0][1] = 1'b1;
		wt(1'b1, 1'b1, 20);
		wt(1'b0, 1'b0, 40);
		chk({6'h00, core_asleep, n >= 40}, 8'h01);
		rd(OFS_IRQ_CONTROL, m[0]);
		u_core.pulse(1'b0);
		#1 chk({6'h00, core_asleep, sleep_as_nop}, 8'h01);
		ev(1'b0, 16'h0000, 1'b0, port_b_pins);
		wr(OFS_IRQ_CONTROL, 8'h90);
		u_core.pulse(1'b0);
		@(posedge ref_clk);
		ext_irq_pin <= 1'b1;
		m[0][1] = 1'b1;
		wt(1'b1, 1'b1, 20);
		wt(1'b0, 1'b1, 40);
		rd(OFS_IRQ_CONTROL, m[0]);
		$display("sleep done");
		end_of_test();
	end
endmodule : test_mcu_interrupt_control

bind mcu_interrupt_control mic_checker u_chk (
	.ref_clk        (ref_clk),
	.rst_n          (rst_n),
	.reg_rd         (reg_rd),
	.reg_rdata      (reg_rdata),
	.sleep_exec     (sleep_exec),
	.irq_vector_req (irq_vector_req),
	.push_return    (push_return),
	.vector_addr    (vector_addr),
	.core_asleep    (core_asleep),
	.wake_req       (wake_req),
	.sleep_as_nop   (sleep_as_nop),
	.instr_en       (instr_en)
);
